// File: logic/pcial_top.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1 - current limiting always active when fitted
// R2 - peak mode: setpoint is peak, phase fire
// R3 - output is lesser of both loop results when fitted, demand loop alone otherwise
// R4 - limit overriding: phase fire, limit alarm
// R5 - enable role gates output, input 2 wins
// R6 - voltage feedback while override input asserted
// R7 - local/remote role selects setpoint source
// R8 - panel local/remote button ignored then
// R9 - phase override role, limit models only
// R10 - source select picks analog 1 or 2
// R11 - logging role overrides stored logging setting
// R12 - bakeout role overrides stored bakeout setting
// R13 - analog 1 scaled against full scale
// R14 - analog 2 scaled with live zero
// R15 - analog 2 as setpoint, feedback, limit
// R16 - relay energized only powered and alarm-free
// R17 - over-temperature always raises the alarm
// R18 - break/short checks only when selected
// R19 - selection chooses sources plus over-temperature
// R20 - digital inputs synchronized and debounced
// R21 - selection decoded to per-source mask bits
module pcial_top
   import pcial_pkg::*;
#(
   parameter bit CL_CAPABLE = 1'b1
) (
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire logic [pcial_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]                 s_axi_awprot,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [pcial_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]                 s_axi_arprot,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   input  wire logic [1:0]                 digital_in_pin,
   input  wire logic                       aux_power_pin,
   input  wire logic                       panel_local_pin,
   input  wire logic [15:0]                analog_in1,
   input  wire logic [15:0]                analog_in2,
   input  wire logic [15:0]                demand_loop_out,
   input  wire logic [15:0]                climit_loop_out,
   input  wire logic [15:0]                peak_current,
   input  wire logic                       heater_break_fault,
   input  wire logic                       shorted_switch_fault,
   input  wire logic                       watchdog_fault,
   input  wire logic                       overtemp_fault,
   output logic [15:0]                     output_level,
   output logic                            phase_angle_fire,
   output logic [2:0]                      feedback_sel,
   output logic [15:0]                     setpoint_pct,
   output logic [15:0]                     climit_setpoint,
   output logic [15:0]                     ext_feedback_pct,
   output logic                            ext_feedback_valid,
   output logic                            current_limit_fault,
   output logic                            logging_on,
   output logic                            bakeout_on,
   output logic                            heater_break_check,
   output logic                            shorted_switch_check,
   output logic                            alarm_active,
   output logic                            relay_energize
);
   import pcial_pkg::*;

   // =====================================
   // helpers
   // =====================================
   // byte-lane merge for partial writes
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return r;
   endfunction : wmerge

   // (v - zero) / (fs - zero) as 0.01 % steps, clamped to 0..100 %
   function automatic logic [15:0] scale_pct(input logic [15:0] v, input logic [15:0] zero,
                                             input logic [15:0] fs);
      logic [31:0] num;
      logic [31:0] den;
      logic [31:0] q;
      num = 32'(v - zero) * 32'(PCT_FULL);
      den = 32'(fs - zero);
      q   = (den == 32'h0000_0000) ? 32'h0000_0000 : num / den;
      if (v <= zero || fs <= zero) begin
         return 16'h0000;
      end
      return (v >= fs || q > 32'(PCT_FULL)) ? PCT_FULL : q[15:0];
   endfunction : scale_pct

   // =====================================
   // pin synchronizers and debounce
   // =====================================
   logic [3:0] pin_s1_q;
   logic [3:0] pin_s2_q;
   logic [1:0] di_db;

   // only the second stage is read anywhere
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_q <= 4'h0;
         pin_s2_q <= 4'h0;
      end else begin
         pin_s1_q <= {panel_local_pin, aux_power_pin, digital_in_pin};   // R20
         pin_s2_q <= pin_s1_q;
      end
   end

   // a level must hold steady a full window before it is believed
   for (genvar i = 0; i < 2; i++) begin : g_deb
      logic [DEB_W-1:0] cnt_q;
      logic             lvl_q;
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            cnt_q <= '0;
            lvl_q <= 1'b0;
         end else if (pin_s2_q[i] == lvl_q) begin
            cnt_q <= '0;
         end else if (cnt_q == DEB_W'(DEB_CYC - 1)) begin
            cnt_q <= '0;
            lvl_q <= pin_s2_q[i];                                  // R20
         end else begin
            cnt_q <= cnt_q + DEB_W'(1);
         end
      end
      assign di_db[i] = lvl_q;
   end

   // =====================================
   // configuration registers
   // =====================================
   logic [31:0] ctrl_q;
   logic [31:0] ai1_q;
   logic [31:0] ai2_q;
   logic [31:0] sp_q;

   wire [2:0] di1_fn    = ctrl_q[F_DI1 +: 3];
   wire [2:0] di2_fn    = ctrl_q[F_DI2 +: 3];
   wire [2:0] fb_cfg    = ctrl_q[F_FB +: 3];
   wire [1:0] fire_cfg  = ctrl_q[F_FIRE +: 2];
   wire       peak_mode = ctrl_q[F_PEAK] & CL_CAPABLE;
   wire [3:0] alm_sel   = ctrl_q[F_ALM +: 4];
   wire [1:0] ai2_fn    = ctrl_q[F_AI2 +: 2];

   // =====================================
   // digital input roles
   // =====================================
   wire has1_en  = (di1_fn == DI_ENABLE);
   wire has2_en  = (di2_fn == DI_ENABLE);
   wire has_vfb  = (di1_fn == DI_VFB) | (di2_fn == DI_VFB);
   wire has_lr   = (di1_fn == DI_LR) | (di2_fn == DI_LR);
   wire has_log  = (di1_fn == DI_LOG) | (di2_fn == DI_LOG);
   wire has_bake = CL_CAPABLE & ((di1_fn == DI_BAKE) | (di2_fn == DI_BAKE));
   wire has_sel  = (di1_fn == DI_SPSEL) | (di2_fn == DI_SPSEL);

   // a role held by both inputs is decided by input 2, except voltage feedback and phase override, which either input asserts
   wire lvl_en   = has2_en ? di_db[1] : (has1_en ? di_db[0] : 1'b1);           // R5
   wire lvl_vfb  = ((di1_fn == DI_VFB) & di_db[0]) | ((di2_fn == DI_VFB) & di_db[1]);
   wire lvl_lr   = (di2_fn == DI_LR) ? di_db[1] : di_db[0];
   wire lvl_ph   = CL_CAPABLE & (((di1_fn == DI_PHASE) & di_db[0]) |
                                 ((di2_fn == DI_PHASE) & di_db[1]));            // R9
   wire lvl_sel  = (di2_fn == DI_SPSEL) ? di_db[1] : di_db[0];
   wire lvl_log  = (di2_fn == DI_LOG) ? di_db[1] : di_db[0];
   wire lvl_bake = (di2_fn == DI_BAKE) ? di_db[1] : di_db[0];

   // =====================================
   // analog scaling and setpoint routing
   // =====================================
   wire [15:0] ai1_pct = scale_pct(analog_in1, 16'h0000, ai1_q[15:0]);          // R13
   wire [15:0] ai2_pct = scale_pct(analog_in2, ai2_q[15:0], ai2_q[31:16]);      // R14
   wire        ai2_cl  = CL_CAPABLE & (ai2_fn == AI2_CLIMIT);                    // R15
   wire        ai2_fb  = (ai2_fn == AI2_EXT_FB);                                 // R15
   wire        local_sel  = has_lr ? lvl_lr : pin_s2_q[3];                       // R7 R8
   wire [15:0] remote_sp  = (has_sel & lvl_sel) ? ai2_pct : ai1_pct;             // R10
   wire [15:0] sp_eff     = local_sel ? sp_q[15:0] : remote_sp;
   wire [15:0] cl_sp      = ai2_cl ? ai2_pct : sp_q[31:16];
   wire [2:0]  fb_eff     = (has_vfb & lvl_vfb) ? FB_VOLTAGE : fb_cfg;           // R6

   // =====================================
   // current limit and output
   // =====================================
   // rms mode: the limit loop wins when it asks for less than demand
   wire cl_rms    = climit_loop_out < demand_loop_out;
   wire cl_peak   = peak_current > cl_sp;                                        // R2
   wire cl_act    = CL_CAPABLE & (peak_mode ? cl_peak : cl_rms);                 // R1 R4
   wire [15:0] lvl_min = (CL_CAPABLE & cl_rms) ? climit_loop_out : demand_loop_out;   // R3
   wire [15:0] out_d   = lvl_en ? lvl_min : 16'h0000;                            // R5
   wire ph_d      = cl_act | lvl_ph | (fire_cfg == FIRE_PHASE);                  // R4 R9

   // =====================================
   // alarm sources
   // =====================================
   wire [3:0] mask_raw = ALM_TABLE[alm_sel];                                      // R21
   wire [3:0] mask     = CL_CAPABLE ? mask_raw : (mask_raw & ~(4'h1 << M_CL));    // R19
   wire [3:0] faults   = {watchdog_fault, cl_act, shorted_switch_fault, heater_break_fault};
   wire alarm_d  = overtemp_fault | (|(mask & faults));                           // R17 R19 R21
   wire relay_d  = pin_s2_q[2] & ~alarm_d;                                        // R16

   // registered block outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         output_level         <= 16'h0000;
         phase_angle_fire     <= 1'b0;
         feedback_sel         <= 3'h0;
         setpoint_pct         <= 16'h0000;
         climit_setpoint      <= 16'h0000;
         ext_feedback_pct     <= 16'h0000;
         ext_feedback_valid   <= 1'b0;
         current_limit_fault  <= 1'b0;
         logging_on           <= 1'b0;
         bakeout_on           <= 1'b0;
         heater_break_check   <= 1'b0;
         shorted_switch_check <= 1'b0;
         alarm_active         <= 1'b0;
         relay_energize       <= 1'b0;
      end else begin
         output_level         <= out_d;
         phase_angle_fire     <= ph_d;
         feedback_sel         <= fb_eff;
         setpoint_pct         <= sp_eff;
         climit_setpoint      <= cl_sp;
         ext_feedback_pct     <= ai2_pct;
         ext_feedback_valid   <= ai2_fb;
         current_limit_fault  <= cl_act;                                           // R4
         logging_on           <= has_log ? lvl_log : ctrl_q[F_LOG];                // R11
         bakeout_on           <= has_bake ? lvl_bake : (CL_CAPABLE & ctrl_q[F_BAKE]); // R12
         heater_break_check   <= mask[M_HB];                                       // R18
         shorted_switch_check <= mask[M_SC];                                       // R18
         alarm_active         <= alarm_d;
         relay_energize       <= relay_d;                                          // R16
      end
   end

   // =====================================
   // AXI4-Lite slave
   // =====================================
   // address and data are taken together, so no skid buffer is needed
   wire wr_go   = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
   wire rd_go   = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
   wire wr_take = s_axi_awready;
   wire rd_take = s_axi_arready;
   wire w_ctrl  = wr_take & (s_axi_awaddr == REG_CTRL);
   wire w_ai1   = wr_take & (s_axi_awaddr == REG_AI1);
   wire w_ai2   = wr_take & (s_axi_awaddr == REG_AI2);
   wire w_sp    = wr_take & (s_axi_awaddr == REG_SP);
   wire w_hit   = w_ctrl | w_ai1 | w_ai2 | w_sp;
   wire [31:0] stat_word = {16'h0000, di_db, local_sel, lvl_en, cl_act, ph_d, alarm_d,
                            relay_d, 5'h00, fb_eff};
   wire r_hit   = (s_axi_araddr == REG_CTRL) | (s_axi_araddr == REG_AI1) |
                  (s_axi_araddr == REG_AI2) | (s_axi_araddr == REG_SP) |
                  (s_axi_araddr == REG_STAT);
   wire [31:0] rd_word = (s_axi_araddr == REG_CTRL) ? ctrl_q :
                         (s_axi_araddr == REG_AI1)  ? ai1_q  :
                         (s_axi_araddr == REG_AI2)  ? ai2_q  :
                         (s_axi_araddr == REG_SP)   ? sp_q   :
                         (s_axi_araddr == REG_STAT) ? stat_word : 32'h0000_0000;

   // register writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= CTRL_RST;
         ai1_q  <= AI1_RST;
         ai2_q  <= AI2_RST;
         sp_q   <= SP_RST;
      end else begin
         if (w_ctrl) ctrl_q <= wmerge(ctrl_q, s_axi_wdata, s_axi_wstrb);
         if (w_ai1)  ai1_q  <= wmerge(ai1_q, s_axi_wdata, s_axi_wstrb);
         if (w_ai2)  ai2_q  <= wmerge(ai2_q, s_axi_wdata, s_axi_wstrb);
         if (w_sp)   sp_q   <= wmerge(sp_q, s_axi_wdata, s_axi_wstrb);
      end
   end

   // write channel handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OK;
      end else begin
         s_axi_awready <= wr_go;
         s_axi_wready  <= wr_go;
         if (wr_take) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= w_hit ? RESP_OK : RESP_ERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read channel handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OK;
      end else begin
         s_axi_arready <= rd_go;
         if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= r_hit ? RESP_OK : RESP_ERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule : pcial_top
`default_nettype wire

// File: logic/pcial_pkg.sv
`default_nettype none
package pcial_pkg;
   // =====================================
   // bus geometry and register map
   // =====================================
   localparam int          ADDR_W    = 5;
   localparam logic [4:0]  REG_CTRL  = 5'h00;
   localparam logic [4:0]  REG_AI1   = 5'h04;
   localparam logic [4:0]  REG_AI2   = 5'h08;
   localparam logic [4:0]  REG_SP    = 5'h0C;
   localparam logic [4:0]  REG_STAT  = 5'h10;
   localparam logic [1:0]  RESP_OK   = 2'h0;
   localparam logic [1:0]  RESP_ERR  = 2'h2;

   // =====================================
   // control word field positions
   // =====================================
   localparam int F_DI1  = 0;
   localparam int F_DI2  = 3;
   localparam int F_FB   = 6;
   localparam int F_FIRE = 9;
   localparam int F_PEAK = 11;
   localparam int F_ALM  = 12;
   localparam int F_AI2  = 16;
   localparam int F_LOG  = 18;
   localparam int F_BAKE = 19;

   // =====================================
   // reset values
   // =====================================
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] AI1_RST  = 32'h0000_FFFF;
   localparam logic [31:0] AI2_RST  = 32'hFFFF_0000;
   localparam logic [31:0] SP_RST   = 32'hFFFF_0000;

   // =====================================
   // encodings
   // =====================================
   typedef enum logic [2:0] {
      DI_NONE, DI_ENABLE, DI_VFB, DI_LR, DI_PHASE, DI_SPSEL, DI_LOG, DI_BAKE
   } pcial_difn_t;
   typedef enum logic [1:0] {AI2_ALT_SP, AI2_EXT_FB, AI2_CLIMIT, AI2_OFF} pcial_ai2fn_t;
   localparam logic [2:0]  FB_VOLTAGE = 3'h0;
   localparam logic [1:0]  FIRE_PHASE = 2'h3;
   localparam logic [15:0] PCT_FULL   = 16'h2710;    // 100.00 % in 0.01 % steps

   // alarm source mask bits and one mask per alarm selection code
   localparam int M_HB = 0;
   localparam int M_SC = 1;
   localparam int M_CL = 2;
   localparam int M_WD = 3;
   localparam logic [3:0] ALM_TABLE [16] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h3, 4'h5, 4'h6, 4'h7,
                                             4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hD, 4'hF};

   // =====================================
   // timing
   // =====================================
   localparam int CLK_PERIOD_NS = 10;
   localparam int DEB_TIME_NS   = 20000;
   localparam int DEB_CYC       = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DEB_W         = 12;
endpackage : pcial_pkg
`default_nettype wire

// File: verif/pcial_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checker
module pcial_monitor #(
   parameter bit CL_CAPABLE = 1'b1
) (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        aux_power_pin,
   input wire logic [15:0] demand_loop_out,
   input wire logic [15:0] climit_loop_out,
   input wire logic        overtemp_fault,
   input wire logic [15:0] output_level,
   input wire logic        phase_angle_fire,
   input wire logic        current_limit_fault,
   input wire logic        alarm_active,
   input wire logic        relay_energize
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // zero output is the enable gate
   out_min_a: assert property (CL_CAPABLE && output_level != 16'h0000 |->
      output_level == (($past(climit_loop_out) < $past(demand_loop_out)) ? $past(climit_loop_out)
      : $past(demand_loop_out))) else $error("output not min");
   limit_phase_a: assert property (current_limit_fault |-> phase_angle_fire)
      else $error("limit without phase");
   hot_alarm_a: assert property ($past(aresetn) && overtemp_fault |=> alarm_active)
      else $error("hot without alarm");
   relay_alarm_a: assert property (alarm_active |-> !relay_energize)
      else $error("relay in alarm");
   // four low samples: two syncs plus the output flop
   relay_aux_a: assert property (!aux_power_pin [*4] |=> !relay_energize)
      else $error("relay unpowered");
   write_pulse_a: assert property (s_axi_awready |-> s_axi_wready ##1 (!s_axi_awready && s_axi_bvalid))
      else $error("write pulse bad");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("bresp dropped");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("rdata dropped");
   read_pulse_a: assert property (s_axi_arready |=> !s_axi_arready && s_axi_rvalid)
      else $error("read pulse bad");
endmodule : pcial_monitor
bind pcial_top pcial_monitor #(.CL_CAPABLE(CL_CAPABLE)) i_mon (.*);
`default_nettype wire

// File: verif/pcial_field_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// field side
module pcial_field_model (
   output var logic [1:0]  digital_in_pin,
   output var logic        aux_power_pin,
   output var logic        panel_local_pin,
   output var logic [15:0] analog_in1,
   output var logic [15:0] analog_in2,
   input  wire logic       aclk
);
   // powered, remote, inputs open at start
   initial begin
      {digital_in_pin, aux_power_pin, panel_local_pin, analog_in1, analog_in2} = {4'h2, 32'h0000_0000};
   end
   // ideal contacts; the caller stages bounce
   task automatic set_pins(input logic [1:0] di, input logic aux, input logic loc);
      @(posedge aclk);
      {digital_in_pin, aux_power_pin, panel_local_pin} <= {di, aux, loc};
   endtask : set_pins
   // sources step; a transmitter would ramp
   task automatic set_analog(input logic [15:0] a1, input logic [15:0] a2);
      @(posedge aclk);
      {analog_in1, analog_in2} <= {a1, a2};
   endtask : set_analog
endmodule : pcial_field_model
`default_nettype wire

// File: verif/power_ctrl_io_alarm_logic_test.sv
`timescale 1ns/1ps
`default_nettype none
module power_ctrl_io_alarm_logic_test;
   import pcial_pkg::*;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic [4:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp, di;
   logic [15:0] demand, climit, peak, out_lvl, sp_pct, cl_sp, ext_pct, ai1, ai2;
   logic [2:0]  fb_sel;
   logic        aux, loc, hb, sc, wd, ot, phase, clf, ext_ok, log_on, bake_on, hb_chk, sc_chk, alarm, relay;
   int          n_mismatch, tests_run;
   // ==========================================
   // clock, design and field side
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   pcial_top i_dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .digital_in_pin(di), .aux_power_pin(aux), .panel_local_pin(loc), .analog_in1(ai1),
      .analog_in2(ai2), .demand_loop_out(demand), .climit_loop_out(climit), .peak_current(peak),
      .heater_break_fault(hb), .shorted_switch_fault(sc), .watchdog_fault(wd), .overtemp_fault(ot),
      .output_level(out_lvl), .phase_angle_fire(phase), .feedback_sel(fb_sel), .setpoint_pct(sp_pct),
      .climit_setpoint(cl_sp), .ext_feedback_pct(ext_pct), .ext_feedback_valid(ext_ok),
      .current_limit_fault(clf), .logging_on(log_on), .bakeout_on(bake_on), .heater_break_check(hb_chk),
      .shorted_switch_check(sc_chk), .alarm_active(alarm), .relay_energize(relay));
   pcial_field_model i_field (.digital_in_pin(di), .aux_power_pin(aux), .panel_local_pin(loc),
      .analog_in1(ai1), .analog_in2(ai2), .aclk(aclk));
   // ==========================================
   // checking and bus tasks
   task automatic report_and_stop();
      $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // sample 1 ns past the edge
   task automatic settle(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask : settle
   task automatic xfer(input bit rd, input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      {awaddr, araddr, wdata} <= {a, a, d};
      {awvalid, wvalid, bready} <= {3{!rd}};
      {arvalid, rready} <= {2{rd}};
      for (int n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (arready) arvalid <= 1'b0;
         if (bvalid | rvalid) begin
            {bready, rready} <= 2'h0;
            if (rd) check(rdata, d);
            check(rd ? rresp : bresp, er);
            return;
         end
      end
      n_mismatch++;
      report_and_stop();
   endtask : xfer
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
      xfer(1'b0, a, d, er);
   endtask : wr
   task automatic rdc(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
      xfer(1'b1, a, ed, er);
   endtask : rdc
   // ==========================================
   // main sequence
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, hb, sc, wd, ot} = '0;
      {awaddr, araddr, wdata, peak} = '0;
      demand = 16'h07D0;
      climit = 16'h2328;
      n_mismatch = 0;
      tests_run = 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      settle(1);
      // reset values, unmapped and read-only places
      rdc(REG_CTRL, CTRL_RST, RESP_OK);
      rdc(REG_AI1, AI1_RST, RESP_OK);
      rdc(REG_AI2, AI2_RST, RESP_OK);
      rdc(REG_SP, SP_RST, RESP_OK);
      rdc(5'h14, 32'h0000_0000, RESP_ERR);
      wr(REG_STAT, 32'hFFFF_FFFF, RESP_ERR);
      wr(REG_AI1, {16'h0000, PCT_FULL}, RESP_OK);
      rdc(REG_AI1, {16'h0000, PCT_FULL}, RESP_OK);
      // rms limiting: limit loop 3000 below demand 5000
      @(posedge aclk);
      climit <= 16'h0BB8;
      demand <= 16'h1388;
      settle(3);
      check(out_lvl, 16'h0BB8);
      check(clf, 1'b1);
      check(phase, 1'b1);
      wr(REG_CTRL, 32'h3 << F_ALM, RESP_OK);
      settle(3);
      check(alarm, 1'b1);
      @(posedge aclk);
      climit <= 16'h2328;
      settle(3);
      check(out_lvl, 16'h1388);
      check(clf, 1'b0);
      // peak mode against a 4000 limit setpoint
      wr(REG_SP, 32'h0FA0_0000, RESP_OK);
      wr(REG_CTRL, 32'h1 << F_PEAK, RESP_OK);
      @(posedge aclk);
      peak <= 16'h1194;
      settle(3);
      check(clf, 1'b1);
      check(phase, 1'b1);
      @(posedge aclk);
      peak <= 16'h0DAC;
      settle(3);
      check(clf, 1'b0);
      check(phase, 1'b0);
      // each alarm selection, then over-temperature
      for (int s = 0; s < 16; s++) begin
         wr(REG_CTRL, 32'(s) << F_ALM, RESP_OK);
         @(posedge aclk);
         {wd, sc, hb} <= 3'(s * 5 + 1);
         settle(3);
         check(hb_chk, ALM_TABLE[s][M_HB]);
         check(sc_chk, ALM_TABLE[s][M_SC]);
         check(alarm, |(ALM_TABLE[s] & {wd, 1'b0, sc, hb}));
         check(relay, ~|(ALM_TABLE[s] & {wd, 1'b0, sc, hb}));
         @(posedge aclk);
         {wd, sc, hb, ot} <= 4'h1;
         settle(2);
         check(alarm, 1'b1);
         @(posedge aclk);
         ot <= 1'b0;
      end
      i_field.set_pins(2'h0, 1'b0, 1'b0);
      settle(6);
      check(relay, 1'b0);
      // analog scaling: 5000 of 10000, and 6000 on a 2000..10000 span
      i_field.set_analog(16'h1388, 16'h1770);
      wr(REG_AI2, {PCT_FULL, 16'h07D0}, RESP_OK);
      wr(REG_CTRL, (32'h3 << F_DI1) | (32'h1 << F_AI2), RESP_OK);
      i_field.set_pins(2'h0, 1'b1, 1'b1);
      settle(6);
      check(sp_pct, 16'h1388);
      check(ext_pct, 16'h1388);
      check(ext_ok, 1'b1);
      wr(REG_CTRL, 32'h2 << F_AI2, RESP_OK);
      settle(3);
      check(cl_sp, 16'h1388);
      check(ext_ok, 1'b0);
      // enable on input 2, logging on input 1 with the stored setting on
      wr(REG_CTRL, (32'h6 << F_DI1) | (32'h1 << F_DI2) | (32'h1 << F_LOG), RESP_OK);
      i_field.set_pins(2'h2, 1'b1, 1'b0);
      settle(100);
      i_field.set_pins(2'h0, 1'b1, 1'b0);
      settle(2010);
      check(out_lvl, 16'h0000);
      check(log_on, 1'b0);
      i_field.set_pins(2'h3, 1'b1, 1'b0);
      settle(2010);
      check(out_lvl, 16'h1388);
      check(log_on, 1'b1);
      wr(REG_CTRL, (32'h1 << F_DI1) | (32'h1 << F_DI2), RESP_OK);
      i_field.set_pins(2'h1, 1'b1, 1'b0);
      settle(2010);
      check(out_lvl, 16'h0000);
      // voltage feedback on input 1, phase override on input 2
      wr(REG_CTRL, (32'h2 << F_DI1) | (32'h4 << F_DI2) | (32'h3 << F_FB), RESP_OK);
      settle(3);
      check(fb_sel, FB_VOLTAGE);
      check(phase, 1'b0);
      i_field.set_pins(2'h2, 1'b1, 1'b0);
      settle(2010);
      check(fb_sel, 3'h3);
      check(phase, 1'b1);
      // source select on input 2; bakeout role on idle input 1
      i_field.set_analog(16'h09C4, 16'h1770);
      wr(REG_CTRL, (32'h5 << F_DI2) | (32'h7 << F_DI1) | (32'h1 << F_BAKE), RESP_OK);
      settle(3);
      check(sp_pct, 16'h1388);
      check(bake_on, 1'b0);
      i_field.set_pins(2'h0, 1'b1, 1'b0);
      settle(2010);
      check(sp_pct, 16'h09C4);
      report_and_stop();
   end
endmodule : power_ctrl_io_alarm_logic_test
`default_nettype wire
